/* hdl/dtsm_map.svh */
`ifndef DTSM_MAP_SVH
`define DTSM_MAP_SVH
// Register indices on the plain register port
`define DTSM_ADDR_W 3
`define DTSM_IDX_TRACK 3'h0
`define DTSM_IDX_MASK 3'h1
`define DTSM_IDX_CMD 3'h2
`define DTSM_IDX_MARKS 3'h3
`define DTSM_IDX_CNT_COUNT 3'h4
`define DTSM_IDX_CNT_KEY 3'h5
`define DTSM_IDX_CNT_DATA 3'h6
// Track orientation fields
`define DTSM_TO_ORIENT_WR 0
`define DTSM_TO_RETRY 1
`define DTSM_TO_FIRST_CMD 2
`define DTSM_TO_FMT_PAD 3
`define DTSM_TO_RW_MODE 4
`define DTSM_TO_XFER 5
`define DTSM_TO_INTENT_LO 6
`define DTSM_TO_INTENT_HI 7
// File permission mask fields
`define DTSM_FM_WR_HOME 0
`define DTSM_FM_FMT_INH 1
`define DTSM_FM_NONFMT_INH 2
`define DTSM_FM_SEEK_LO 3
`define DTSM_FM_SEEK_HI 4
`define DTSM_FM_DIAG 5
`define DTSM_FM_MASK_SET 6
`define DTSM_FM_PCI_FETCH 7
// Read/write mark fields
`define DTSM_RW_CHAN_END 0
`define DTSM_RW_NO_SEEK_LOAD 1
`define DTSM_RW_OFFSET 2
`define DTSM_RW_QSEEK 6
`define DTSM_RW_QSEEK_EOC 7
`define DTSM_RW_USED_MASK 8'hc7
`define DTSM_RESET_BYTE 8'h00
`endif

/* hdl/dtsm_pkg.sv */
package dtsm_pkg;
    typedef enum logic [1:0] {INTENT_READ, INTENT_UPDATE, INTENT_FORMAT, INTENT_TRACK} dtsm_intent_t;
    typedef enum logic [1:0] {SEEK_ALL, SEEK_CYL_HEAD, SEEK_HEAD_ONLY, SEEK_NONE} dtsm_seek_t;
    typedef enum logic [2:0] {
        CMD_READ, CMD_WRITE_HOME, CMD_WRITE_FORMAT, CMD_WRITE_UPDATE,
        CMD_SEEK_CYL_HEAD, CMD_SEEK_HEAD, CMD_SEEK_OTHER, CMD_DIAG
    } dtsm_cmd_class_t;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dtsm_reg_req_t;
    typedef struct packed {
        logic start_io;
        logic initial_sel;
        logic new_cmd;
        logic [7:0] cmd_word;
        logic cmd_is_command;
        logic set_mask_cmd;
        logic [7:0] set_mask_val;
        logic count_setup;
        logic key_setup;
        logic data_setup;
        logic chan_end_only;
        logic unit_finish_sent;
        logic load_seek_suppr;
        logic load_read_exec;
        logic offset_on;
        logic offset_reset;
        logic queued_seek;
        logic chain_disc_qseek;
    } dtsm_event_t;
    typedef struct packed {
        logic valid;
        dtsm_cmd_class_t cls;
        logic ce_track;
    } dtsm_check_t;
endpackage

/* hdl/dtsm_state_regs.sv */
`timescale 1ns/10ps
`include "dtsm_map.svh"
module dtsm_state_regs #(
    parameter int CNT_W = 8
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input dtsm_pkg::dtsm_reg_req_t req_i,
    output logic [7:0] rdata_o,
    input dtsm_pkg::dtsm_event_t evt_i,
    input dtsm_pkg::dtsm_check_t chk_i,
    output logic chk_allow_o,
    output logic chk_reject_o,
    output logic diag_mode_o,
    output logic home_retry_allow_o,
    output logic pci_fetch_o,
    output logic xfer_mode_o
);
    import dtsm_pkg::*;

    // Counters are read back through an 8-bit port
    if (CNT_W < 1 || CNT_W > 8)
    begin : g_bad_cnt_w
        $error("CNT_W must be 1 to 8");
    end

    logic [7:0] track;
    logic [7:0] mask;
    logic [7:0] cmd;
    logic [7:0] marks;
    logic [7:0] marks_alt;
    logic [CNT_W-1:0] cnt [3];
    logic [7:0] rdata;
    logic [7:0] next_marks;
    logic [7:0] next_mask;

    wire wr_track = req_i.wr && req_i.addr == `DTSM_IDX_TRACK;
    wire wr_mask = req_i.wr && req_i.addr == `DTSM_IDX_MASK;
    wire wr_cmd = req_i.wr && req_i.addr == `DTSM_IDX_CMD;
    wire wr_marks = req_i.wr && req_i.addr == `DTSM_IDX_MARKS;
    wire in_xfer = track[`DTSM_TO_XFER];

    // Field usage counters: count, key, data
    wire [2:0] cnt_inc = {evt_i.data_setup, evt_i.key_setup, evt_i.count_setup};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_cnt
            wire wr_this = req_i.wr && req_i.addr == (`DTSM_IDX_CNT_COUNT + 3'(gi));
            always_ff @(posedge core_clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    cnt[gi] <= '0;
                else if (evt_i.start_io)
                    cnt[gi] <= '0;
                else if (cnt_inc[gi])
                    cnt[gi] <= cnt[gi] + CNT_W'(1);
                else if (wr_this)
                    cnt[gi] <= req_i.wdata[CNT_W-1:0];
            end
        end
    endgenerate

    // Orientation flags and write intent, software written
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            track <= `DTSM_RESET_BYTE;
        else if (wr_track)
            track <= req_i.wdata;
    end

    wire [1:0] intent = track[`DTSM_TO_INTENT_HI:`DTSM_TO_INTENT_LO];

    // Mask: set-file-mask command loads it and sets the seen bit
    always_comb
    begin
        next_mask = mask;
        if (wr_mask)
            next_mask = req_i.wdata;
        if (evt_i.initial_sel)
            next_mask[`DTSM_FM_MASK_SET] = 1'b0;
        if (evt_i.set_mask_cmd)
        begin
            next_mask = evt_i.set_mask_val;
            next_mask[`DTSM_FM_MASK_SET] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            mask <= `DTSM_RESET_BYTE;
        else
            mask <= next_mask;
    end

    // Command word: overwritten only, never cleared
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cmd <= `DTSM_RESET_BYTE;
        else if (evt_i.initial_sel || evt_i.new_cmd)
            cmd <= evt_i.cmd_word;
        else if (wr_cmd)
            cmd <= req_i.wdata;
    end

    // Marks: sets win over clears
    always_comb
    begin
        next_marks = marks;
        if (wr_marks)
            next_marks = req_i.wdata;
        if (evt_i.unit_finish_sent)
            next_marks[`DTSM_RW_CHAN_END] = 1'b0;
        if (evt_i.chan_end_only)
            next_marks[`DTSM_RW_CHAN_END] = 1'b1;
        if (evt_i.load_read_exec)
            next_marks[`DTSM_RW_NO_SEEK_LOAD] = 1'b0;
        if (evt_i.load_seek_suppr)
            next_marks[`DTSM_RW_NO_SEEK_LOAD] = 1'b1;
        if (evt_i.cmd_is_command || evt_i.initial_sel || evt_i.offset_reset)
            next_marks[`DTSM_RW_OFFSET] = 1'b0;
        if (evt_i.offset_on)
            next_marks[`DTSM_RW_OFFSET] = 1'b1;
        if (evt_i.initial_sel)
        begin
            next_marks[`DTSM_RW_QSEEK] = 1'b0;
            next_marks[`DTSM_RW_QSEEK_EOC] = 1'b0;
        end
        if (evt_i.queued_seek)
            next_marks[`DTSM_RW_QSEEK] = 1'b1;
        if (evt_i.chain_disc_qseek)
            next_marks[`DTSM_RW_QSEEK_EOC] = 1'b1;
        next_marks = next_marks & `DTSM_RW_USED_MASK;
    end

    // Mark events only act outside transfer mode; inside, register reused
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            marks <= `DTSM_RESET_BYTE;
        else if (!in_xfer)
            marks <= next_marks;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            marks_alt <= `DTSM_RESET_BYTE;
        else if (in_xfer && wr_marks)
            marks_alt <= req_i.wdata;
    end

    // Permission check
    wire [1:0] seek_code = mask[`DTSM_FM_SEEK_HI:`DTSM_FM_SEEK_LO];
    wire is_seek = chk_i.cls == CMD_SEEK_CYL_HEAD || chk_i.cls == CMD_SEEK_HEAD
        || chk_i.cls == CMD_SEEK_OTHER;
    wire diag = mask[`DTSM_FM_DIAG];
    wire seek_code_ok = (seek_code == SEEK_ALL)
        || (seek_code == SEEK_CYL_HEAD && chk_i.cls != CMD_SEEK_OTHER)
        || (seek_code == SEEK_HEAD_ONLY && chk_i.cls == CMD_SEEK_HEAD);
    wire seek_ok = seek_code_ok && (!diag || chk_i.ce_track);
    wire home_ok = mask[`DTSM_FM_WR_HOME];
    wire fmt_ok = !mask[`DTSM_FM_FMT_INH];
    wire upd_ok = !mask[`DTSM_FM_NONFMT_INH];
    logic allow;
    always_comb
    begin
        case (chk_i.cls)
            CMD_READ: allow = 1'b1;
            CMD_WRITE_HOME: allow = home_ok;
            CMD_WRITE_FORMAT: allow = fmt_ok;
            CMD_WRITE_UPDATE: allow = upd_ok;
            CMD_DIAG: allow = diag;
            default: allow = is_seek && seek_ok;
        endcase
    end
    assign chk_allow_o = chk_i.valid && allow;
    assign chk_reject_o = chk_i.valid && !allow;
    assign diag_mode_o = diag;
    assign home_retry_allow_o = !diag;
    assign pci_fetch_o = mask[`DTSM_FM_PCI_FETCH];
    assign xfer_mode_o = in_xfer;

    // Read mux, data one cycle after strobe
    logic [7:0] rsel;
    always_comb
    begin
        case (req_i.addr)
            `DTSM_IDX_TRACK: rsel = track;
            `DTSM_IDX_MASK: rsel = mask;
            `DTSM_IDX_CMD: rsel = cmd;
            `DTSM_IDX_MARKS: rsel = in_xfer ? marks_alt : marks;
            `DTSM_IDX_CNT_COUNT: rsel = 8'(cnt[0]);
            `DTSM_IDX_CNT_KEY: rsel = 8'(cnt[1]);
            `DTSM_IDX_CNT_DATA: rsel = 8'(cnt[2]);
            default: rsel = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rdata <= `DTSM_RESET_BYTE;
        else if (req_i.rd)
            rdata <= rsel;
        else
            rdata <= `DTSM_RESET_BYTE;
    end
    assign rdata_o = rdata;
    wire unused_intent = ^intent;
endmodule

/* sim/dtsm_state_regs_sva.sv */
`timescale 1ns/10ps
module dtsm_state_regs_chk (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input dtsm_pkg::dtsm_reg_req_t req_i,
    input logic [7:0] rdata_o,
    input dtsm_pkg::dtsm_event_t evt_i,
    input dtsm_pkg::dtsm_check_t chk_i,
    input logic chk_allow_o,
    input logic chk_reject_o,
    input logic diag_mode_o,
    input logic home_retry_allow_o,
    input logic pci_fetch_o,
    input logic xfer_mode_o
);
    import dtsm_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    query_excl_a: assert property ((chk_allow_o ^ chk_reject_o) == chk_i.valid)
        else $error("query answer");
    diag_cmd_a: assert property (chk_i.valid && chk_i.cls == CMD_DIAG |->
        chk_allow_o == diag_mode_o) else $error("diag cmd");
    diag_seek_a: assert property (chk_i.valid && diag_mode_o && !chk_i.ce_track &&
        chk_i.cls inside {CMD_SEEK_CYL_HEAD, CMD_SEEK_HEAD, CMD_SEEK_OTHER} |-> chk_reject_o)
        else $error("diag seek");
    retry_inhibit_a: assert property (home_retry_allow_o != diag_mode_o)
        else $error("retry flag");
    mask_cmd_a: assert property (evt_i.set_mask_cmd |=>
        pci_fetch_o == $past(evt_i.set_mask_val[7])) else $error("mask cmd");
    mask_wr_a: assert property (req_i.wr && req_i.addr == 3'h1 && !evt_i.set_mask_cmd |=>
        diag_mode_o == $past(req_i.wdata[5])) else $error("mask write");
    xfer_flag_a: assert property (req_i.wr && req_i.addr == 3'h0 |=>
        xfer_mode_o == $past(req_i.wdata[5])) else $error("xfer flag");
    mask_back_a: assert property ((req_i.wr && req_i.addr == 3'h1 && !evt_i.set_mask_cmd
        && !evt_i.initial_sel) ##1 (req_i.rd && req_i.addr == 3'h1)
        |=> rdata_o == $past(req_i.wdata, 2)) else $error("mask read");
    cover property (chk_allow_o && chk_i.cls == CMD_DIAG);
    cover property (chk_reject_o && diag_mode_o);
    cover property (evt_i.set_mask_cmd);
endmodule
bind dtsm_state_regs dtsm_state_regs_chk u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .req_i(req_i), .rdata_o(rdata_o), .evt_i(evt_i), .chk_i(chk_i), .chk_allow_o(chk_allow_o),
    .chk_reject_o(chk_reject_o), .diag_mode_o(diag_mode_o),
    .home_retry_allow_o(home_retry_allow_o), .pci_fetch_o(pci_fetch_o), .xfer_mode_o(xfer_mode_o));

/* sim/dtsm_host_model.sv */
`timescale 1ns/10ps
module dtsm_host_model (
    input wire logic core_clk_i,
    output dtsm_pkg::dtsm_event_t evt_o
);
    import dtsm_pkg::*;
    initial evt_o <= '0;
    // One event pulse, then an optional slow gap
    task automatic send(input dtsm_event_t e, input int slow);
        @(posedge core_clk_i);
        evt_o <= e;
        @(posedge core_clk_i);
        evt_o <= '0;
        repeat (slow) @(posedge core_clk_i);
    endtask
endmodule

/* sim/tb_disk_track_state_and_file_mask.sv */
`timescale 1ns/10ps
module tb_disk_track_state_and_file_mask;
    import dtsm_pkg::*;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    dtsm_reg_req_t req_i = '0;
    dtsm_check_t chk_i = '0;
    dtsm_event_t evt_i;
    dtsm_event_t e;
    logic [7:0] rdata_o;
    logic chk_allow_o, chk_reject_o, diag_mode_o, home_retry_allow_o, pci_fetch_o, xfer_mode_o;
    int fails = 0;
    int checks = 0;
    // Per entry: ce_track, mask, allow bit per command class
    logic [16:0] tbl [8] = '{{1'b0, 8'h00, 8'h7d}, {1'b0, 8'h07, 8'h73}, {1'b0, 8'h09, 8'h3f},
        {1'b0, 8'h11, 8'h2f}, {1'b0, 8'h19, 8'h0f}, {1'b1, 8'h21, 8'hff},
        {1'b0, 8'h21, 8'h8f}, {1'b0, 8'h81, 8'h7f}};
    always #4 core_clk_i = ~core_clk_i;
    dtsm_state_regs #(.CNT_W(8)) u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .req_i(req_i), .rdata_o(rdata_o), .evt_i(evt_i), .chk_i(chk_i), .chk_allow_o(chk_allow_o),
        .chk_reject_o(chk_reject_o), .diag_mode_o(diag_mode_o),
        .home_retry_allow_o(home_retry_allow_o), .pci_fetch_o(pci_fetch_o),
        .xfer_mode_o(xfer_mode_o));
    dtsm_host_model u_host (.core_clk_i(core_clk_i), .evt_o(evt_i));
    task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Optional write, then a read of the same index
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
        input logic [7:0] exp);
        if (w)
        begin
            @(posedge core_clk_i);
            req_i <= '{a, d, 1'b1, 1'b0};
        end
        @(posedge core_clk_i);
        req_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk_i);
        req_i <= '0;
        #1 cmp(rdata_o, exp);
    endtask
    task automatic q(input int c, input logic ce, input logic ok);
        @(posedge core_clk_i);
        chk_i <= '{1'b1, dtsm_cmd_class_t'(c[2:0]), ce};
        #1 cmp({6'h00, chk_allow_o, chk_reject_o}, {6'h00, ok, !ok});
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        fails++;
        stop_test;
    end
    initial
    begin
        repeat (5) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 8; i++) acc(0, i[2:0], 8'h00, 8'h00);
        for (int i = 0; i < 4; i++) acc(1, 3'h0, {i[1:0], 6'h15}, {i[1:0], 6'h15});
        acc(1, 3'h0, 8'h3f, 8'h3f);
        cmp({7'h00, xfer_mode_o}, 8'h01);
        acc(1, 3'h3, 8'h38, 8'h38);
        e = '0;
        e.chan_end_only = 1'b1;
        u_host.send(e, 3);
        acc(1, 3'h0, 8'h00, 8'h00);
        acc(0, 3'h3, 8'h00, 8'h00);
        $display("track test done");
        foreach (tbl[k])
        begin
            acc(1, 3'h1, tbl[k][15:8], tbl[k][15:8]);
            cmp({5'h00, home_retry_allow_o, diag_mode_o, pci_fetch_o},
                {5'h00, !tbl[k][13], tbl[k][13], tbl[k][15]});
            for (int c = 0; c < 8; c++) q(c, tbl[k][16], tbl[k][c]);
        end
        $display("mask test done");
        e = '0;
        e.set_mask_cmd = 1'b1;
        e.set_mask_val = 8'h05;
        u_host.send(e, 2);
        acc(0, 3'h1, 8'h00, 8'h45);
        e = '0;
        e.initial_sel = 1'b1;
        e.new_cmd = 1'b1;
        e.cmd_word = 8'h3c;
        u_host.send(e, 0);
        acc(0, 3'h2, 8'h00, 8'h3c);
        acc(0, 3'h1, 8'h00, 8'h05);
        e = '0;
        {e.count_setup, e.key_setup, e.data_setup} = 3'h7;
        u_host.send(e, 0);
        u_host.send(e, 0);
        e.key_setup = 1'b0;
        u_host.send(e, 0);
        for (int i = 4; i < 7; i++) acc(0, i[2:0], 8'h00, (i == 5) ? 8'h02 : 8'h03);
        e = '0;
        e.start_io = 1'b1;
        u_host.send(e, 0);
        acc(0, 3'h6, 8'h00, 8'h00);
        acc(1, 3'h4, 8'h5a, 8'h5a);
        acc(0, 3'h2, 8'h00, 8'h3c);
        e = '0;
        {e.chan_end_only, e.load_seek_suppr, e.offset_on, e.queued_seek} = 4'hf;
        e.chain_disc_qseek = 1'b1;
        u_host.send(e, 0);
        acc(0, 3'h3, 8'h00, 8'hc7);
        e = '0;
        {e.unit_finish_sent, e.load_read_exec} = 2'h3;
        u_host.send(e, 0);
        acc(0, 3'h3, 8'h00, 8'hc4);
        e = '0;
        {e.new_cmd, e.cmd_is_command, e.cmd_word} = {2'h3, 8'h5a};
        u_host.send(e, 0);
        acc(0, 3'h3, 8'h00, 8'hc0);
        e = '0;
        {e.offset_on, e.offset_reset} = 2'h3;
        u_host.send(e, 0);
        acc(0, 3'h3, 8'h00, 8'hc4);
        e.offset_on = 1'b0;
        u_host.send(e, 0);
        acc(0, 3'h3, 8'h00, 8'hc0);
        e = '0;
        e.initial_sel = 1'b1;
        u_host.send(e, 0);
        acc(0, 3'h3, 8'h00, 8'h00);
        acc(1, 3'h3, 8'hff, 8'hc7);
        $display("marks test done");
        stop_test;
    end
endmodule
